// ==== rtl/ecu_defines.svh ====
// register offsets, field positions, reset values and mode codes
// assumes inclusion by the capture unit files, one shared definition set
`ifndef ECU_DEFINES_SVH
`define ECU_DEFINES_SVH

// word byte addresses on the avalon slave
`define ECU_OFS_CTRL1   8'h00
`define ECU_OFS_SRC1    8'h04
`define ECU_OFS_CAPL1   8'h08
`define ECU_OFS_CAPH1   8'h0c
`define ECU_OFS_CTRL2   8'h10
`define ECU_OFS_SRC2    8'h14
`define ECU_OFS_CAPL2   8'h18
`define ECU_OFS_CAPH2   8'h1c
`define ECU_OFS_FLAG    8'h20
`define ECU_OFS_ENABLE  8'h24

// control register fields
`define ECU_CTRL_EN_BIT   7
`define ECU_CTRL_OUT_BIT  5
`define ECU_CTRL_FMT_BIT  4
`define ECU_CTRL_MODE_HI  3
`define ECU_CTRL_WMASK    8'hbf
`define ECU_CTRL_RST      8'h00
`define ECU_SRC_RST       8'h00

// event mode codes
`define ECU_MODE_FALL     4'h4
`define ECU_MODE_RISE     4'h5
`define ECU_MODE_RISE4    4'h6
`define ECU_MODE_RISE16   4'h7
`define ECU_DIV4_LAST     4'h3
`define ECU_DIV16_LAST    4'hf

`endif

// ==== rtl/ecu_pkg.sv ====
// types shared by the capture unit files
// assumes the defines header supplies all numeric constants
package ecu_pkg;
  typedef logic [15:0] ecu_count_t;
  typedef logic [7:0] ecu_byte_t;
endpackage

// ==== rtl/ecu_sync_edge.sv ====
// two-flop synchroniser with rise and fall detection for one source
// assumes an asynchronous input; outputs are on clk_sys_i
`timescale 1ns/1ps
module ecu_sync_edge (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // async level in, edges out
  input wire logic level_i,
  output logic rise_o,
  output logic fall_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // first flop read only by the second
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= level_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // compare successive synchronised samples
  assign rise_o = sync_r & ~prev_r;
  assign fall_o = ~sync_r & prev_r;
endmodule

// ==== rtl/ecu_capture_unit.sv ====
// one capture channel: source select, prescaler, captured count
// assumes a synchronous timer count and edge pulses from the synchroniser
`timescale 1ns/1ps
`include "ecu_defines.svh"
module ecu_capture_unit import ecu_pkg::*; (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // configuration
  input wire logic [7:0] ctrl_i,
  input wire logic [2:0] src_sel_i,
  // edge pulses of the eight sources
  input wire logic [7:0] rise_i,
  input wire logic [7:0] fall_i,
  // timer count
  input wire logic [15:0] count_i,
  // result
  output ecu_count_t captured_o,
  output logic capture_o
);
  logic [3:0] mode;
  logic enabled;
  logic is_capture;
  logic rise;
  logic fall;
  logic [3:0] presc_r;
  logic hit;

  assign mode = ctrl_i[`ECU_CTRL_MODE_HI:0];
  assign enabled = ctrl_i[`ECU_CTRL_EN_BIT];
  assign is_capture = (mode == `ECU_MODE_FALL) || (mode == `ECU_MODE_RISE) ||
                      (mode == `ECU_MODE_RISE4) || (mode == `ECU_MODE_RISE16);
  // pin source edges seen regardless of pin direction
  assign rise = rise_i[src_sel_i];
  assign fall = fall_i[src_sel_i];

  // qualifying event decode
  always_comb begin
    hit = 1'b0;
    if (enabled) begin
      case (mode)
        `ECU_MODE_FALL: hit = fall;
        `ECU_MODE_RISE: hit = rise;
        `ECU_MODE_RISE4: hit = rise &&
          (presc_r[1:0] == 2'(`ECU_DIV4_LAST));
        `ECU_MODE_RISE16: hit = rise && (presc_r == `ECU_DIV16_LAST);
        default: hit = 1'b0;
      endcase
    end
  end

  // prescaler keeps its count across direct mode switches, a known hazard
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      presc_r <= 4'h0;
    end else if (!enabled || !is_capture) begin
      presc_r <= 4'h0;
    end else if (mode == `ECU_MODE_RISE4 && hit) begin
      presc_r <= 4'h0;
    end else if (rise) begin
      presc_r <= presc_r + 4'h1;
    end
  end

  // latch the count; no overrun guard
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      captured_o <= 16'h0000;
      capture_o <= 1'b0;
    end else begin
      capture_o <= hit;
      if (hit) begin
        captured_o <= count_i;
      end
    end
  end
endmodule

// ==== rtl/ecu_top.sv ====
// two capture channels with avalon-mm register access and one interrupt
// assumes the timer count is synchronous to clk_sys_i; sources are async
`timescale 1ns/1ps
`include "ecu_defines.svh"
module ecu_top import ecu_pkg::*; (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // first general timer count, same clock
  input wire logic [7:0] first_timer_count_high_i,
  input wire logic [7:0] first_timer_count_low_i,
  // capture sources of unit one
  input wire logic routed_pin_input1_i,
  // capture sources of unit two
  input wire logic routed_pin_input2_i,
  // shared sources
  input wire logic comparator_one_synced_i,
  input wire logic comparator_two_synced_i,
  input wire logic pin_change_event_i,
  input wire logic logic_cell_one_output_i,
  input wire logic logic_cell_two_output_i,
  input wire logic logic_cell_three_output_i,
  input wire logic logic_cell_four_output_i,
  // interrupt
  output logic irq_o
);
  //////////////////////////////////////////////////////////////////////
  // registers
  ecu_byte_t ctrl1_r;
  ecu_byte_t ctrl2_r;
  logic [2:0] src1_r;
  logic [2:0] src2_r;
  logic [1:0] flag_r;
  logic [1:0] enable_r;
  logic ack_r;
  ecu_count_t cap1;
  ecu_count_t cap2;
  logic capt1;
  logic capt2;
  logic [8:0] rise;
  logic [8:0] fall;
  logic [8:0] levels;
  logic [15:0] count;
  logic acc;
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_nxt;

  assign count = {first_timer_count_high_i, first_timer_count_low_i};

  //////////////////////////////////////////////////////////////////////
  // source synchronisers; shared ones are synchronised once for both
  assign levels = {routed_pin_input2_i, logic_cell_four_output_i,
                   logic_cell_three_output_i, logic_cell_two_output_i,
                   logic_cell_one_output_i, pin_change_event_i,
                   comparator_two_synced_i, comparator_one_synced_i,
                   routed_pin_input1_i};
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_sync
      ecu_sync_edge u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .level_i(levels[gi]),
        .rise_o(rise[gi]),
        .fall_o(fall[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // two identical channels, each with its own prescaler and capture register
  ecu_capture_unit u_unit1 (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .ctrl_i(ctrl1_r),
    .src_sel_i(src1_r),
    .rise_i(rise[7:0]),
    .fall_i(fall[7:0]),
    .count_i(count),
    .captured_o(cap1),
    .capture_o(capt1)
  );
  ecu_capture_unit u_unit2 (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .ctrl_i(ctrl2_r),
    .src_sel_i(src2_r),
    .rise_i({rise[7:1], rise[8]}),
    .fall_i({fall[7:1], fall[8]}),
    .count_i(count),
    .captured_o(cap2),
    .capture_o(capt2)
  );

  //////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then the answer
  assign acc = (avs_read_i || avs_write_i) && !ack_r;
  assign wr_go = avs_write_i && ack_r;
  assign rd_go = avs_read_i && !ack_r;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      ack_r <= acc;
      avs_waitrequest_o <= !acc;
    end
  end

  // configuration writes; only byte lane 0 holds data
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl1_r <= `ECU_CTRL_RST;
      ctrl2_r <= `ECU_CTRL_RST;
      src1_r <= 3'h0;
      src2_r <= 3'h0;
      enable_r <= 2'h0;
    end else if (wr_go && avs_byteenable_i[0]) begin
      case (avs_address_i)
        `ECU_OFS_CTRL1: ctrl1_r <= avs_writedata_i[7:0] & `ECU_CTRL_WMASK;
        `ECU_OFS_CTRL2: ctrl2_r <= avs_writedata_i[7:0] & `ECU_CTRL_WMASK;
        `ECU_OFS_SRC1: src1_r <= avs_writedata_i[2:0];
        `ECU_OFS_SRC2: src2_r <= avs_writedata_i[2:0];
        `ECU_OFS_ENABLE: enable_r <= avs_writedata_i[1:0];
        default: ;
      endcase
    end
  end

  // sticky flags, write one to clear; a capture in the same cycle wins
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_r <= 2'h0;
    end else begin
      if (wr_go && avs_byteenable_i[0] && avs_address_i == `ECU_OFS_FLAG)
        flag_r <= (flag_r & ~avs_writedata_i[1:0]) | {capt2, capt1};
      else
        flag_r <= flag_r | {capt2, capt1};
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (avs_address_i)
      `ECU_OFS_CTRL1: rd_nxt = {24'h0, ctrl1_r};
      `ECU_OFS_CTRL2: rd_nxt = {24'h0, ctrl2_r};
      `ECU_OFS_SRC1: rd_nxt = {29'h0, src1_r};
      `ECU_OFS_SRC2: rd_nxt = {29'h0, src2_r};
      `ECU_OFS_CAPL1: rd_nxt = {24'h0, cap1[7:0]};
      `ECU_OFS_CAPH1: rd_nxt = {24'h0, cap1[15:8]};
      `ECU_OFS_CAPL2: rd_nxt = {24'h0, cap2[7:0]};
      `ECU_OFS_CAPH2: rd_nxt = {24'h0, cap2[15:8]};
      `ECU_OFS_FLAG: rd_nxt = {30'h0, flag_r};
      `ECU_OFS_ENABLE: rd_nxt = {30'h0, enable_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data registered in the wait cycle, valid when waitrequest drops
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata_o <= rd_nxt;
    end
  end

  // level interrupt from unmasked flags
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flag_r & enable_r);
    end
  end
endmodule

// ==== testbench/ecu_partner.sv ====
// timer count model standing beside the capture unit
// assumes the bench either loads a fixed count or lets it run
`timescale 1ns/1ps
module ecu_partner (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // bench control
  input wire logic [15:0] load_i,
  input wire logic hold_i,
  // timer count
  output logic [7:0] cnt_hi_o,
  output logic [7:0] cnt_lo_o
);
  logic [1:0] div_r;
  logic [15:0] cnt_r;
  // steps at a quarter of the clock, synchronous; held lets captures be known
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_r <= 2'h0;
      cnt_r <= 16'h0000;
    end else if (hold_i) begin
      cnt_r <= load_i;
    end else begin
      div_r <= div_r + 2'h1;
      cnt_r <= (div_r == 2'h3) ? cnt_r + 16'h0001 : cnt_r;
    end
  end
  assign cnt_hi_o = cnt_r[15:8];
  assign cnt_lo_o = cnt_r[7:0];
endmodule

// ==== testbench/ecu_top_chk.sv ====
// bus and interrupt checks on the capture unit top ports
// assumes one clock domain and a bind to every ecu_top
`timescale 1ns/1ps
module ecu_top_chk (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // a new request, and a read completing
  sequence s_req;
    $rose(avs_read_i || avs_write_i);
  endsequence
  sequence s_rd_done;
    avs_read_i && !avs_waitrequest_o;
  endsequence
  AST_ACK_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("ack longer than one cycle");
  AST_ACK_SOON: assert property (s_req |-> ##[1:2] !avs_waitrequest_o)
    else $error("access not answered");
  AST_ACK_CAUSE: assert property
    (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("ack without request");
  AST_RD_HOLD: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without read");
  AST_UNMAPPED_ZERO: assert property
    (s_rd_done and avs_address_i >= 8'h28 |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_BYTE_WIDE: assert property (s_rd_done |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_CTRL_RSVD: assert property (s_rd_done and
    (avs_address_i == 8'h00 || avs_address_i == 8'h10) |-> !avs_readdata_o[6])
    else $error("control bit 6 reads one");
  AST_IRQ_STICKY: assert property (irq_o && !avs_write_i &&
    !$past(avs_write_i) && !$past(avs_write_i, 2) |=> irq_o)
    else $error("interrupt dropped without a write");
endmodule
bind ecu_top ecu_top_chk i_ecu_top_chk (.clk_sys_i, .reset_n_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o, .irq_o);

// ==== testbench/event_capture_unit_bench.sv ====
// self-checking bench for the two-channel event capture unit
// assumes ecu_top, its defines header and the timer count model
`timescale 1ns/1ps
`include "ecu_defines.svh"
module event_capture_unit_bench;
  localparam logic [7:0] C1 = `ECU_OFS_CTRL1;
  localparam logic [7:0] FL = `ECU_OFS_FLAG;
  logic clk_sys_i, reset_n_i, rd, wr, hold, wt, irq;
  logic [7:0] adr, wd, chi, clo;
  logic [8:0] sv; // source levels, bit 8 is the unit two pin
  logic [15:0] ld;
  logic [31:0] rdat, q;
  int error_cnt, n_checks, cyc;
  // device and timer count model
  ecu_top i_ecu_top (.clk_sys_i, .reset_n_i, .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i({24'h0, wd}),
    .avs_byteenable_i(4'h1), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .first_timer_count_high_i(chi), .first_timer_count_low_i(clo),
    .routed_pin_input1_i(sv[0]), .routed_pin_input2_i(sv[8]),
    .comparator_one_synced_i(sv[1]), .comparator_two_synced_i(sv[2]),
    .pin_change_event_i(sv[3]), .logic_cell_one_output_i(sv[4]),
    .logic_cell_two_output_i(sv[5]), .logic_cell_three_output_i(sv[6]),
    .logic_cell_four_output_i(sv[7]), .irq_o(irq));
  ecu_partner i_ecu_partner (.clk_sys_i, .reset_n_i, .load_i(ld),
    .hold_i(hold), .cnt_hi_o(chi), .cnt_lo_o(clo));
  // 40 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // hang guard, far beyond the longest sequence
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk_sys_i);
    while (wt !== 1'b0) @(posedge clk_sys_i);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e);
    n_checks++;
    if (q !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, q);
    end
  endtask
  task automatic rc(input logic [7:0] a, input string nm, input logic [31:0] e);
    rw(1'b0, a, 8'h00);
    chk(nm, e);
  endtask
  task automatic ci(input logic e);
    q = {31'h0, irq};
    chk("irq", {31'h0, e});
  endtask
  // source level step; long enough for sync and flag
  task automatic lv(input int i, input logic v);
    sv[i] <= v;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task automatic pls(input int i);
    lv(i, 1'b1);
    lv(i, 1'b0);
  endtask
  task automatic t_regs;
    rc(C1, "ctrl reset", 32'h0);
    rc(FL, "flag reset", 32'h0);
    rw(1'b1, C1, 8'hff);
    rc(C1, "ctrl", 32'hbf);
    rw(1'b1, 8'h28, 8'h5a);
    rc(8'h28, "unmapped", 32'h0);
  endtask
  task automatic t_cap;
    rw(1'b1, C1, 8'h00);
    rw(1'b1, `ECU_OFS_ENABLE, 8'h01);
    rw(1'b1, C1, 8'h85);
    rw(1'b1, FL, 8'h03);
    for (int k = 0; k < 2; k++) begin
      ld <= k ? 16'hbeef : 16'h1234;
      pls(0);
      rc(`ECU_OFS_CAPL1, "cap low", k ? 32'hef : 32'h34);
      rc(`ECU_OFS_CAPH1, "cap high", k ? 32'hbe : 32'h12);
      rc(FL, "flag", 32'h1);
    end
    ci(1'b1);
    rw(1'b1, FL, 8'h01);
    rc(FL, "flag clear", 32'h0);
    ci(1'b0);
  endtask
  task automatic t_fall;
    rw(1'b1, C1, 8'h84);
    rw(1'b1, FL, 8'h01);
    lv(0, 1'b1);
    rc(FL, "rise in fall mode", 32'h0);
    lv(0, 1'b0);
    rc(FL, "fall", 32'h1);
  endtask
  task automatic t_div(input logic [7:0] c, input int n);
    rw(1'b1, C1, c);
    pls(0);
    pls(0);
    rw(1'b1, C1, 8'h00);
    rw(1'b1, C1, c);
    rw(1'b1, FL, 8'h01);
    repeat (n - 1) pls(0);
    rc(FL, "early", 32'h0);
    pls(0);
    rc(FL, "divided", 32'h1);
  endtask
  task automatic t_src;
    for (int i = 0; i < 8; i++) begin
      rw(1'b1, C1, 8'h00);
      rw(1'b1, `ECU_OFS_SRC1, 8'(i));
      rw(1'b1, C1, 8'h85);
      rw(1'b1, FL, 8'h01);
      pls((i + 1) % 8);
      rc(FL, "other source", 32'h0);
      pls(i);
      rc(FL, "source", 32'h1);
    end
  endtask
  task automatic t_two;
    rw(1'b1, C1, 8'h00);
    rw(1'b1, `ECU_OFS_CTRL2, 8'h85);
    rw(1'b1, FL, 8'h03);
    ld <= 16'h0f0f;
    pls(8);
    rc(`ECU_OFS_CAPL2, "cap2 low", 32'h0f);
    rc(FL, "flag2", 32'h2);
    ci(1'b0);
    rw(1'b1, `ECU_OFS_ENABLE, 8'h02);
    rc(`ECU_OFS_CAPH2, "cap2 high", 32'h0f);
    ci(1'b1);
    rw(1'b1, FL, 8'h02);
    rc(FL, "flag2 clear", 32'h0);
    ci(1'b0);
  endtask
  // reset, then the scenarios
  initial begin
    reset_n_i = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 8'h00;
    sv = 9'h000;
    ld = 16'h0000;
    hold = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_regs;
    hold <= 1'b1;
    t_cap;
    t_fall;
    t_div(8'h86, 4);
    t_div(8'h87, 16);
    t_src;
    t_two;
    end_sim;
  end
endmodule
